// [iwd_pkg.sv]
// Notes on behaviour
// - every fetched instruction is one 14-bit word: opcode on top, operands below
// - byte ops: dest bit clear sends result to W, set sends it to file
// - file address is a 7-bit field, 0x00 to 0x7F
// - bit ops: 3-bit field picks one of eight bits in the register
// - literal ops carry an 8-bit constant, jump and call an 11-bit target
// - an instruction normally takes exactly one instruction cycle
// - taken skip or altered program counter costs two cycles, second is a no-op; here a bit op writing PCL still takes one cycle
// - one instruction cycle is four oscillator periods
// - don't-care bits are ignored; generators should fill them with zero (the testbench drives 0x0060 and fills them randomly)
// - three groups: byte, bit, literal/control, each with its own layout
// - word 0x0063 enters sleep, one cycle, touches timeout and powerdown flags
// - word 0x0064 clears watchdog, one cycle, touches timeout and powerdown flags
// - byte write to timer zero clears its prescaler when assigned to it
package iwd_pkg;
   localparam int WORD_W = 14;
   localparam int FADDR_W = 7;
   localparam int BITSEL_W = 3;
   localparam int LIT8_W = 8;
   localparam int LIT11_W = 11;
   localparam int GRP_LSB = 12;
   localparam int DEST_POS = 7;
   localparam int BITSEL_LSB = 7;
   localparam int PHASES = 4;
   localparam logic [1:0] GRP_BYTE = 2'h0;
   localparam logic [1:0] GRP_BIT = 2'h1;
   localparam logic [1:0] GRP_JUMP = 2'h2;
   localparam logic [1:0] GRP_LIT = 2'h3;
   localparam logic [13:0] OP_SLEEP = 14'h0063;
   localparam logic [13:0] OP_WATCHDOG_CLR = 14'h0064;
   localparam logic [13:0] OP_RETURN = 14'h0008;
   localparam logic [13:0] OP_RETFIE = 14'h0009;
   localparam logic [6:0] TIMER_ZERO_ADDR = 7'h01;
   localparam logic [6:0] PCL_ADDR = 7'h02;
   localparam logic [1:0] PH_LAST = 2'h3;
   typedef enum logic [2:0] {
      IWD_ST_IDLE = 3'h1,
      IWD_ST_EXEC = 3'h2,
      IWD_ST_FLUSH = 3'h4
   } iwd_state_t;
endpackage

// [iwd_field_split.sv]
`timescale 1ns/100ps
`default_nettype none
module iwd_field_split (
   // word
   input wire logic [13:0] word,
   // fields
   output logic [1:0] group,
   output logic [3:0] byte_op,
   output logic [1:0] bit_op,
   output logic dest,
   output logic [6:0] faddr,
   output logic [2:0] bitsel,
   output logic [7:0] lit8,
   output logic [10:0] lit11
);
   assign group = word[13:12];
   assign byte_op = word[11:8];
   assign bit_op = word[11:10];
   assign dest = word[iwd_pkg::DEST_POS];
   assign faddr = word[6:0];
   assign bitsel = word[9:7];
   assign lit8 = word[7:0];
   assign lit11 = word[10:0];
endmodule
`default_nettype wire

// [instruction_word_decoder.sv]
`timescale 1ns/100ps
`default_nettype none
module iwd_instruction_word_decoder (
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // program memory
   input wire logic [13:0] instr_word,
   input wire logic instr_valid,
   output logic fetch_strobe,
   output logic fetch_discard,
   // core status inputs
   input wire logic skip_cond,
   input wire logic prescaler_on_timer,
   // decoded outputs
   output logic [1:0] op_group,
   output logic [3:0] op_code,
   output logic [6:0] file_addr,
   output logic [2:0] bit_sel,
   output logic [7:0] literal8,
   output logic [10:0] literal11,
   output logic write_w,
   output logic write_file,
   output logic pc_load,
   output logic exec_valid,
   output logic sleep_req,
   output logic watchdog_clear_op,
   output logic timer_prescaler_clear,
   output logic [1:0] phase
);
   typedef struct packed {
      iwd_pkg::iwd_state_t st;
      logic [1:0] ph;
      logic [13:0] ir;
      logic [1:0] grp;
      logic [3:0] opc;
      logic [6:0] fa;
      logic [2:0] bs;
      logic [7:0] k8;
      logic [10:0] k11;
      logic ww;
      logic wf;
      logic pcl;
      logic ev;
      logic slp;
      logic wdc;
      logic psc;
   } iwd_regs_t;

   iwd_regs_t r_q, r_d;
   logic [1:0] f_grp, f_bitop;
   logic [3:0] f_byte;
   logic f_dest;
   logic [6:0] f_fa;
   logic [2:0] f_bs;
   logic [7:0] f_k8;
   logic [10:0] f_k11;
   logic end_cycle, is_skip, is_branch, byte_wr;

   iwd_field_split u_split (
      .word(r_q.ir),
      .group(f_grp),
      .byte_op(f_byte),
      .bit_op(f_bitop),
      .dest(f_dest),
      .faddr(f_fa),
      .bitsel(f_bs),
      .lit8(f_k8),
      .lit11(f_k11)
   );

   assign end_cycle = (r_q.ph == iwd_pkg::PH_LAST);

   always_comb begin
      r_d = r_q;
      is_skip = 1'b0;
      is_branch = 1'b0;
      byte_wr = 1'b0;
      r_d.ph = r_q.ph + 2'h1;
      r_d.ev = 1'b0;
      r_d.slp = 1'b0;
      r_d.wdc = 1'b0;
      r_d.psc = 1'b0;
      r_d.pcl = 1'b0;
      r_d.ww = 1'b0;
      r_d.wf = 1'b0;
      if (end_cycle) begin
         case (r_q.st)
            iwd_pkg::IWD_ST_IDLE: begin
               if (instr_valid) begin
                  r_d.ir = instr_word;
                  r_d.st = iwd_pkg::IWD_ST_EXEC;
               end
            end
            iwd_pkg::IWD_ST_EXEC: begin
               r_d.grp = f_grp;
               r_d.fa = f_fa;
               r_d.bs = f_bs;
               r_d.k8 = f_k8;
               r_d.k11 = f_k11;
               r_d.opc = f_byte;
               r_d.ev = 1'b1;
               case (f_grp)
                  iwd_pkg::GRP_BYTE: begin
                     if (r_q.ir == iwd_pkg::OP_SLEEP) begin
                        r_d.slp = 1'b1;
                     end else if (r_q.ir == iwd_pkg::OP_WATCHDOG_CLR) begin
                        r_d.wdc = 1'b1;
                     end else if (r_q.ir == iwd_pkg::OP_RETURN
                                  || r_q.ir == iwd_pkg::OP_RETFIE) begin
                        is_branch = 1'b1;
                     end else if (f_byte == 4'h0) begin
                        // store W when bit 7 set; bits 6:5 of nop ignored
                        byte_wr = f_dest;
                     end else if (f_byte == 4'h1) begin
                        byte_wr = f_dest;
                        r_d.ww = ~f_dest;
                     end else begin
                        byte_wr = f_dest;
                        r_d.ww = ~f_dest;
                        is_skip = (f_byte == 4'hB || f_byte == 4'hF) && skip_cond;
                     end
                     r_d.wf = byte_wr;
                     r_d.psc = byte_wr && f_fa == iwd_pkg::TIMER_ZERO_ADDR
                               && prescaler_on_timer;
                     if (byte_wr && f_fa == iwd_pkg::PCL_ADDR) begin
                        is_branch = 1'b1;
                     end
                  end
                  iwd_pkg::GRP_BIT: begin
                     r_d.wf = ~f_bitop[1];
                     r_d.psc = ~f_bitop[1] && f_fa == iwd_pkg::TIMER_ZERO_ADDR
                               && prescaler_on_timer;
                     is_skip = f_bitop[1] && skip_cond;
                  end
                  iwd_pkg::GRP_JUMP: begin
                     is_branch = 1'b1;
                  end
                  default: begin
                     // literal ops; low x bits are ignored
                     r_d.ww = 1'b1;
                     is_branch = (f_byte[3:2] == 2'h1);
                  end
               endcase
               r_d.pcl = is_branch;
               if (is_skip || is_branch) begin
                  r_d.st = iwd_pkg::IWD_ST_FLUSH;
               end else begin
                  r_d.st = iwd_pkg::IWD_ST_IDLE;
               end
            end
            iwd_pkg::IWD_ST_FLUSH: begin
               r_d.st = iwd_pkg::IWD_ST_IDLE;
            end
            default: begin
               r_d.st = iwd_pkg::IWD_ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         r_q <= '0;
         r_q.st <= iwd_pkg::IWD_ST_IDLE;
      end else begin
         r_q <= r_d;
      end
   end

   assign fetch_strobe = end_cycle && r_q.st == iwd_pkg::IWD_ST_IDLE;
   assign fetch_discard = end_cycle && r_q.st == iwd_pkg::IWD_ST_FLUSH;
   assign op_group = r_q.grp;
   assign op_code = r_q.opc;
   assign file_addr = r_q.fa;
   assign bit_sel = r_q.bs;
   assign literal8 = r_q.k8;
   assign literal11 = r_q.k11;
   assign write_w = r_q.ww;
   assign write_file = r_q.wf;
   assign pc_load = r_q.pcl;
   assign exec_valid = r_q.ev;
   assign sleep_req = r_q.slp;
   assign watchdog_clear_op = r_q.wdc;
   assign timer_prescaler_clear = r_q.psc;
   assign phase = r_q.ph;
endmodule
`default_nettype wire

// [iwd_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
module iwd_monitor (
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // fetch side
   input wire logic instr_valid,
   input wire logic fetch_strobe,
   input wire logic fetch_discard,
   // decode side
   input wire logic [1:0] op_group,
   input wire logic [6:0] file_addr,
   input wire logic write_w,
   input wire logic write_file,
   input wire logic pc_load,
   input wire logic exec_valid,
   input wire logic sleep_req,
   input wire logic watchdog_clear_op,
   input wire logic timer_prescaler_clear,
   input wire logic [1:0] phase
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   chk_fetch_phase: assert property (fetch_strobe |-> phase == 2'h3)
      else $error("fetch off phase");
   chk_exec_delay: assert property (fetch_strobe && instr_valid |-> ##[4:5] exec_valid)
      else $error("late result");
   chk_exec_phase: assert property (exec_valid |-> phase == 2'h0)
      else $error("result off phase");
   chk_exec_single: assert property (exec_valid |=> !exec_valid)
      else $error("result too long");
   chk_dest_excl: assert property (write_w |-> exec_valid && !write_file)
      else $error("two destinations");
   chk_sleep_pulse: assert property (sleep_req |-> exec_valid && op_group == 2'h0)
      else $error("bad sleep");
   chk_watchdog_pulse: assert property (watchdog_clear_op |-> exec_valid && !sleep_req)
      else $error("bad watchdog clear");
   chk_pre_clear: assert property (timer_prescaler_clear |->
      write_file && file_addr == iwd_pkg::TIMER_ZERO_ADDR)
      else $error("bad prescaler clear");
   chk_branch_flush: assert property (exec_valid && pc_load |-> ##3 fetch_discard)
      else $error("no flush");
   chk_flush_nofetch: assert property (fetch_discard |-> !fetch_strobe)
      else $error("fetch in flush");
endmodule
bind iwd_instruction_word_decoder iwd_monitor mon (.clk_sys, .nrst, .instr_valid, .fetch_strobe,
   .fetch_discard, .op_group, .file_addr, .write_w, .write_file, .pc_load, .exec_valid,
   .sleep_req, .watchdog_clear_op, .timer_prescaler_clear, .phase);
`default_nettype wire

// [iwd_prog_mem.sv]
`timescale 1ns/100ps
`default_nettype none
module iwd_prog_mem (
   input wire logic clk_sys,
   input wire logic fetch_strobe,
   output logic [13:0] instr_word,
   output logic instr_valid
);
   logic [13:0] words[$];
   logic taken;
   initial begin
      instr_word = 14'h0000;
      instr_valid = 1'b0;
      taken = 1'b0;
   end
   always @(posedge clk_sys) taken <= fetch_strobe && instr_valid;
   // one whole word per fetch, then the bus shows garbage
   always @(negedge clk_sys) begin
      if (taken) begin
         void'(words.pop_front());
         instr_valid = 1'b0;
         instr_word = ~instr_word;
      end
      if (!instr_valid && words.size() > 0) begin
         instr_word = words[0];
         instr_valid = 1'b1;
      end
   end
endmodule
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic clk_sys, nrst, skip_cond, prescaler_on_timer, instr_valid, fetch_strobe, fetch_discard;
   logic [13:0] instr_word;
   logic [1:0] op_group, phase;
   logic [3:0] op_code;
   logic [6:0] file_addr;
   logic [2:0] bit_sel;
   logic [7:0] literal8;
   logic [10:0] literal11;
   logic write_w, write_file, pc_load, exec_valid, sleep_req, watchdog_clear_op;
   logic timer_prescaler_clear;
   int num_errors = 0;
   int tests_run = 0;
   integer seed = 32'hb190ba2b;
   iwd_instruction_word_decoder uut (.clk_sys, .nrst, .instr_word, .instr_valid, .fetch_strobe,
      .fetch_discard, .skip_cond, .prescaler_on_timer, .op_group, .op_code, .file_addr, .bit_sel,
      .literal8, .literal11, .write_w, .write_file, .pc_load, .exec_valid, .sleep_req,
      .watchdog_clear_op, .timer_prescaler_clear, .phase);
   iwd_prog_mem pm (.clk_sys, .fetch_strobe, .instr_word, .instr_valid);
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   task automatic chk(input logic [10:0] got, input logic [10:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic run_op(input logic [13:0] w, input logic sk, input logic pre);
      logic [1:0] g;
      logic wf, ww, br, skp, psc;
      int n, disc;
      g = w[13:12];
      wf = (g == 2'h0 && w[7]) || (g == 2'h1 && !w[11]);
      ww = (g == 2'h0 && !w[7] && w[11:8] != 4'h0) || g == 2'h3;
      br = g == 2'h2 || (g == 2'h3 && w[11:10] == 2'h1) || w == iwd_pkg::OP_RETURN
         || w == iwd_pkg::OP_RETFIE || (g == 2'h0 && w[7] && w[6:0] == iwd_pkg::PCL_ADDR);
      skp = sk && ((g == 2'h0 && w[11] && w[9:8] == 2'h3) || (g == 2'h1 && w[11]));
      psc = wf && w[6:0] == iwd_pkg::TIMER_ZERO_ADDR && pre;
      @(negedge clk_sys);
      skip_cond = sk;
      prescaler_on_timer = pre;
      pm.words.push_back(w);
      n = 0;
      while (exec_valid !== 1'b1) begin
         @(negedge clk_sys);
         n++;
         if (n > 30) begin
            $display("[ERR] %0t no result", $time);
            num_errors++;
            report_and_stop();
         end
      end
      chk(op_group, g, "group");
      chk(phase, 2'h0, "phase");
      if (!g[1]) chk(file_addr, w[6:0], "faddr");
      if (g == 2'h1) chk(bit_sel, w[9:7], "bit");
      if (g == 2'h3) chk(literal8, w[7:0], "lit8");
      if (g == 2'h2) chk(literal11, w[10:0], "lit11");
      chk({write_w, write_file}, {ww, wf}, "dest");
      if (g == 2'h0) chk(op_code, w[11:8], "opcode");
      chk(pc_load, br, "pcload");
      chk(sleep_req, w == iwd_pkg::OP_SLEEP, "sleep");
      chk(watchdog_clear_op, w == iwd_pkg::OP_WATCHDOG_CLR, "watchdog");
      chk(timer_prescaler_clear, psc, "pre");
      disc = 0;
      repeat (8) begin
         @(negedge clk_sys);
         disc += (fetch_discard === 1'b1);
      end
      chk(11'(disc), br || skp, "flush");
      $display("op %h done", w);
   endtask
   initial begin
      logic [13:0] w;
      logic [31:0] r;
      nrst = 1'b0;
      skip_cond = 1'b0;
      prescaler_on_timer = 1'b0;
      repeat (10) @(negedge clk_sys);
      nrst = 1'b1;
      run_op(iwd_pkg::OP_SLEEP, 1'b0, 1'b0);
      run_op(iwd_pkg::OP_WATCHDOG_CLR, 1'b1, 1'b0);
      run_op(14'h0781, 1'b0, 1'b1);
      run_op(14'h0781, 1'b0, 1'b0);
      run_op(14'h0701, 1'b0, 1'b1);
      run_op(14'h0081, 1'b0, 1'b1);
      run_op(14'h1401, 1'b0, 1'b1);
      run_op(iwd_pkg::OP_RETURN, 1'b0, 1'b0);
      run_op(iwd_pkg::OP_RETFIE, 1'b0, 1'b0);
      run_op(14'h0082, 1'b0, 1'b0);
      run_op(14'h0B85, 1'b1, 1'b0);
      run_op(14'h0385, 1'b1, 1'b0);
      run_op(14'h0103, 1'b0, 1'b0);
      run_op(14'h0181, 1'b0, 1'b0);
      run_op(14'h0060, 1'b1, 1'b0);
      for (int i = 0; i < 80; i++) begin
         w = 14'($random(seed));
         r = $random(seed);
         if (!w[13]) w[5] = 1'b1;
         if (w[13:8] == 6'h00) w[7] = 1'b1; // never the legacy loads
         run_op(w, r[0], r[1]);
      end
      report_and_stop();
   end
endmodule
`default_nettype wire
